/* verilog/remote_control_heartbeat_regs.sv */
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module remote_control_heartbeat_regs
  import rc_hb_pkg::*;
#(
  parameter int TICK_COUNT   = TICK_CYCLES,
  parameter int WINDOW_TICKS = HB_WINDOW_TICKS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  input  wire logic        local_operator_panel,
  output logic             comm_fault,
  output logic             contactors_closed,
  output logic             power_enable,
  output logic             start_pulse,
  output logic             stop_pulse,
  output logic             fault_reset_pulse,
  output logic             irq
);

  logic [31:0]      tick_cnt_q;
  logic             tick_q;
  logic [15:0]      dev_alive_q;
  logic [15:0]      host_alive_q;
  logic             hb_armed_q;
  logic [7:0]       hb_age_q;
  logic             comm_fault_q;
  logic             hb_bad;
  logic             hb_late;
  logic             hb_wr;
  logic             fc_wr;
  logic             cmd_wr;
  logic             cmd_bad;
  unit_state_t      unit_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic [15:0]      rdata_q;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  assign hb_wr  = wr_en && hit(addr, OFS_HOST_ALIVE);
  assign fc_wr  = wr_en && hit(addr, OFS_FAULT_CLEAR);
  assign cmd_wr = wr_en && hit(addr, OFS_OP_CMD);

  // one-second prescaler
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_COUNT - 1)) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q     <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_alive_q <= ZERO16;
    end else if (tick_q) begin
      if (dev_alive_q >= ALIVE_MAX) begin
        dev_alive_q <= ZERO16;
      end else begin
        dev_alive_q <= dev_alive_q + 16'h0001;
      end
    end
  end

  // host write sequence check; zero after zero is a break
  always_comb begin
    hb_bad = 1'b0;
    if (hb_wr && hb_armed_q) begin
      if (wdata == ZERO16) begin
        hb_bad = (host_alive_q == ZERO16);
      end else begin
        hb_bad = (wdata != host_alive_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_alive_q <= ZERO16;
      hb_armed_q   <= 1'b0;
    end else if (hb_wr) begin
      host_alive_q <= wdata;
      hb_armed_q   <= 1'b1;
    end
  end

  // age in ticks since last host write; window is a tolerance parameter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_age_q <= 8'h00;
    end else if (hb_wr) begin
      hb_age_q <= 8'h00;
    end else if (tick_q && hb_age_q != 8'hFF) begin
      hb_age_q <= hb_age_q + 8'h01;
    end
  end

  // overdue host write; age saturates at 255 and the window is cut to its low 8 bits, so a window past 255 ticks wraps
  assign hb_late = hb_armed_q && !hb_wr
                && hb_age_q >= 8'(WINDOW_TICKS);

  // fault is sticky until a fault clear; a new break beats the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_fault_q <= 1'b0;
    end else if (hb_bad || hb_late) begin
      comm_fault_q <= 1'b1;
    end else if (fc_wr && wdata == FAULT_CLR_MAX) begin
      comm_fault_q <= 1'b0;
    end
  end

  assign cmd_bad = (cmd_wr && wdata > CMD_RESUME)
                || (fc_wr && wdata > FAULT_CLR_MAX);

  // unit mode; commands are pulses, register always reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_q <= UNIT_STOPPED;
    end else if (cmd_wr) begin
      case (wdata)
        CMD_START:   unit_q <= UNIT_RUNNING;
        CMD_STOP:    unit_q <= UNIT_STOPPED;
        CMD_STANDBY: begin
          if (unit_q == UNIT_RUNNING) begin
            unit_q <= UNIT_STANDBY;
          end
        end
        CMD_RESUME: begin
          if (unit_q == UNIT_STANDBY) begin
            unit_q <= UNIT_RUNNING;
          end
        end
        default: unit_q <= unit_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_pulse       <= 1'b0;
      stop_pulse        <= 1'b0;
      fault_reset_pulse <= 1'b0;
    end else begin
      start_pulse       <= cmd_wr && wdata == CMD_START;
      stop_pulse        <= cmd_wr && wdata == CMD_STOP;
      fault_reset_pulse <= fc_wr && wdata == FAULT_CLR_MAX;
    end
  end

  assign comm_fault        = comm_fault_q;
  assign contactors_closed = (unit_q != UNIT_STOPPED);
  assign power_enable      = (unit_q == UNIT_RUNNING);

  // interrupt status: write one to clear, a new event wins
  assign irq_evt = {cmd_bad, tick_q, hb_bad || (!comm_fault_q && hb_late)};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else if (wr_en && hit(addr, OFS_IRQ_STATUS)) begin
      irq_stat_q <= (irq_stat_q & ~wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (wr_en && hit(addr, OFS_IRQ_MASK)) begin
      irq_mask_q <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read port: data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ZERO16;
    end else if (rd_en) begin
      case (addr)
        OFS_MODEL_ID:    rdata_q <= MODEL_ID_VAL;
        OFS_MODEL_LEN:   rdata_q <= MODEL_LEN_VAL;
        OFS_CTRL_SRC:    rdata_q <= {15'h0000, local_operator_panel};
        OFS_DEV_ALIVE:   rdata_q <= dev_alive_q;
        OFS_HOST_ALIVE:  rdata_q <= host_alive_q;
        OFS_FAULT_CLEAR: rdata_q <= ZERO16;
        OFS_OP_CMD:      rdata_q <= ZERO16;
        OFS_IRQ_STATUS:  rdata_q <= {13'h0000, irq_stat_q};
        OFS_IRQ_MASK:    rdata_q <= {13'h0000, irq_mask_q};
        OFS_DEV_STATUS:  rdata_q <= {12'h000, hb_armed_q, comm_fault_q,
                                     power_enable, contactors_closed};
        default:         rdata_q <= ZERO16;
      endcase
    end else begin
      rdata_q <= ZERO16;
    end
  end

  assign rdata = rdata_q;

  // assertions
  property p_alive_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (tick_q && dev_alive_q == ALIVE_MAX) |=> dev_alive_q == ZERO16;
  endproperty
  a_alive_wrap: assert property (p_alive_wrap)
    else $error("alive counter did not wrap");

  property p_alive_step;
    @(posedge sys_clk) disable iff (!rst_n)
      (tick_q && dev_alive_q < ALIVE_MAX)
        |=> dev_alive_q == $past(dev_alive_q) + 16'h0001;
  endproperty
  a_alive_step: assert property (p_alive_step)
    else $error("alive counter did not step");

  property p_alive_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !tick_q |=> $stable(dev_alive_q);
  endproperty
  a_alive_hold: assert property (p_alive_hold)
    else $error("alive counter moved without tick");

  property p_id_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_en && addr == OFS_MODEL_ID) |=> rdata == MODEL_ID_VAL;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("model id read wrong");

  property p_len_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_en && addr == OFS_MODEL_LEN) |=> rdata == MODEL_LEN_VAL;
  endproperty
  a_len_read: assert property (p_len_read)
    else $error("model length read wrong");

  property p_src_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_en && addr == OFS_CTRL_SRC)
        |=> rdata == {15'h0000, $past(local_operator_panel)};
  endproperty
  a_src_read: assert property (p_src_read)
    else $error("control source read wrong");

  property p_double_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (hb_wr && hb_armed_q && wdata == ZERO16 && host_alive_q == ZERO16)
        |=> comm_fault;
  endproperty
  a_double_zero: assert property (p_double_zero)
    else $error("double zero not faulted");

  property p_unarmed;
    @(posedge sys_clk) disable iff (!rst_n)
      !hb_armed_q |-> !comm_fault;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("fault while checking disarmed");

  property p_standby;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_wr && wdata == CMD_STANDBY && unit_q == UNIT_RUNNING)
        |=> contactors_closed && !power_enable;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby wrong");

  property p_bad_cmd;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_wr && wdata > CMD_RESUME) |=> $stable(unit_q) && !start_pulse;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("bad command acted");

  property p_cmd_reads_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_en && addr == OFS_OP_CMD) |=> rdata == ZERO16;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command reg not zero");

  property p_late;
    @(posedge sys_clk) disable iff (!rst_n)
      hb_late |=> comm_fault;
  endproperty
  a_late: assert property (p_late)
    else $error("overdue host write not faulted");

  property p_bad_step;
    @(posedge sys_clk) disable iff (!rst_n)
      (hb_wr && hb_armed_q && wdata != ZERO16
       && wdata != host_alive_q + 16'h0001) |=> comm_fault;
  endproperty
  a_bad_step: assert property (p_bad_step)
    else $error("broken host sequence not faulted");

  property p_fault_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (fc_wr && wdata == FAULT_CLR_MAX && !hb_bad && !hb_late)
        |=> !comm_fault && fault_reset_pulse;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault clear had no effect");

  property p_clear_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (fc_wr && wdata == ZERO16 && comm_fault)
        |=> comm_fault && !fault_reset_pulse;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("zero fault clear acted");

  property p_start;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_wr && wdata == CMD_START)
        |=> start_pulse && contactors_closed && power_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("start command not obeyed");

  property p_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_wr && wdata == CMD_STOP)
        |=> stop_pulse && !contactors_closed && !power_enable;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop command not obeyed");

  property p_resume;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_wr && wdata == CMD_RESUME && unit_q == UNIT_STANDBY)
        |=> contactors_closed && power_enable;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume command not obeyed");

  c_start: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_wr && wdata == CMD_START);
  c_fault: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(comm_fault));
  c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
    tick_q && dev_alive_q == ALIVE_MAX);
  c_resume: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_wr && wdata == CMD_RESUME && unit_q == UNIT_STANDBY);

endmodule
`default_nettype wire

/* verilog/rc_hb_pkg.sv */
`default_nettype none
package rc_hb_pkg;
  // register indices; byte address = index * 4 is not used on this plain port
  localparam logic [15:0] OFS_MODEL_ID     = 16'hA09D;
  localparam logic [15:0] OFS_MODEL_LEN    = 16'hA09E;
  localparam logic [15:0] OFS_CTRL_SRC     = 16'hA09F;
  localparam logic [15:0] OFS_DEV_ALIVE    = 16'hA0A0;
  localparam logic [15:0] OFS_HOST_ALIVE   = 16'hA0A1;
  localparam logic [15:0] OFS_FAULT_CLEAR  = 16'hA0A2;
  localparam logic [15:0] OFS_OP_CMD       = 16'hA0A3;
  localparam logic [15:0] OFS_IRQ_STATUS   = 16'hA0A4;
  localparam logic [15:0] OFS_IRQ_MASK     = 16'hA0A5;
  localparam logic [15:0] OFS_DEV_STATUS   = 16'hA0A6;
  // arbitrary neutral identity value
  localparam logic [15:0] MODEL_ID_VAL     = 16'h1234;
  localparam logic [15:0] MODEL_LEN_VAL    = 16'h0008;
  localparam logic [15:0] ALIVE_MAX        = 16'h7FFF;
  localparam logic [15:0] FAULT_CLR_MAX    = 16'h0001;
  localparam logic [15:0] CMD_START        = 16'h0001;
  localparam logic [15:0] CMD_STOP         = 16'h0002;
  localparam logic [15:0] CMD_STANDBY      = 16'h0003;
  localparam logic [15:0] CMD_RESUME       = 16'h0004;
  localparam logic [15:0] ZERO16           = 16'h0000;
  // status / mask bit positions
  localparam int IRQ_COMM_FAULT  = 0;
  localparam int IRQ_TICK        = 1;
  localparam int IRQ_BAD_CMD     = 2;
  localparam int IRQ_W           = 3;
  // timing
  localparam int SYS_CLK_HZ      = 50_000_000;
  localparam int TICK_PERIOD_S   = 1;
  localparam int TICK_CYCLES     = SYS_CLK_HZ * TICK_PERIOD_S;
  localparam int HB_WINDOW_TICKS = 2;
  typedef enum logic [1:0] {
    UNIT_STOPPED,
    UNIT_RUNNING,
    UNIT_STANDBY
  } unit_state_t;
endpackage
`default_nettype wire

/* dv/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model
  import rc_hb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] rdata,
  output logic      [15:0] addr,
  output logic      [15:0] wdata,
  output logic             wr_en,
  output logic             rd_en
);
  logic [15:0] hb_q;
  initial begin
    addr = ZERO16;
    wdata = ZERO16;
    wr_en = 1'b0;
    rd_en = 1'b0;
    hb_q = ZERO16;
  end
  // idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
  // each beat carries the last value plus one
  task automatic beat();
    hb_q = hb_q + 16'h0001;
    wr(OFS_HOST_ALIVE, hb_q);
  endtask
  // zero restarts the sequence; twice in a row is a fault
  task automatic beat_zero();
    hb_q = ZERO16;
    wr(OFS_HOST_ALIVE, hb_q);
  endtask
endmodule
`default_nettype wire

/* dv/remote_control_heartbeat_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module remote_control_heartbeat_regs_tb
  import rc_hb_pkg::*;
;
  localparam int TICKS = 2;
  localparam int WIN = 20;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        local_operator_panel = 1'b0;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        wr_en;
  logic        rd_en;
  logic        comm_fault;
  logic        contactors_closed;
  logic        power_enable;
  logic        start_pulse;
  logic        stop_pulse;
  logic        fault_reset_pulse;
  logic        irq;
  logic [3:0]  n_start = 4'h0;
  logic [3:0]  n_stop = 4'h0;
  logic [3:0]  n_clr = 4'h0;
  logic [15:0] v;
  int          num_errors = 0;
  int          num_checks = 0;
  always #10 sys_clk = ~sys_clk;
  // one-cycle pulses are counted so they can be checked later
  always @(posedge sys_clk) begin
    if (start_pulse === 1'b1) n_start <= n_start + 4'h1;
    if (stop_pulse === 1'b1) n_stop <= n_stop + 4'h1;
    if (fault_reset_pulse === 1'b1) n_clr <= n_clr + 4'h1;
  end
  remote_control_heartbeat_regs #(.TICK_COUNT(TICKS), .WINDOW_TICKS(WIN)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .local_operator_panel(local_operator_panel), .comm_fault(comm_fault),
    .contactors_closed(contactors_closed), .power_enable(power_enable),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse),
    .fault_reset_pulse(fault_reset_pulse), .irq(irq));
  host_model host (.sys_clk(sys_clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // fault, contactors, power, irq
  task automatic chk_pins(input string nm, input logic [3:0] e);
    @(posedge sys_clk);
    #1 chk(nm, {12'h000, e},
           {12'h000, comm_fault, contactors_closed, power_enable, irq});
  endtask
  // start, stop, fault reset pulse counts
  task automatic chk_cnt(input string nm, input logic [11:0] e);
    chk(nm, {4'h0, e}, {4'h0, n_start, n_stop, n_clr});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_rd(OFS_MODEL_ID, MODEL_ID_VAL);
    chk_rd(OFS_MODEL_LEN, MODEL_LEN_VAL);
    chk_rd(OFS_CTRL_SRC, ZERO16);
    chk_rd(OFS_HOST_ALIVE, ZERO16);
    chk_rd(OFS_FAULT_CLEAR, ZERO16);
    chk_rd(OFS_OP_CMD, ZERO16);
    chk_rd(16'hA0B0, ZERO16);
    host.wr(OFS_MODEL_ID, 16'hFFFF);
    host.wr(OFS_MODEL_LEN, 16'h0001);
    chk_rd(OFS_MODEL_ID, MODEL_ID_VAL);
    chk_rd(OFS_MODEL_LEN, MODEL_LEN_VAL);
    @(posedge sys_clk);
    local_operator_panel <= 1'b1;
    chk_rd(OFS_CTRL_SRC, 16'h0001);
    $display("test header done");
    // a read every two cycles sees every step of the counter
    host.rd(OFS_DEV_ALIVE, v);
    for (int i = 0; i < 40000 && v !== ALIVE_MAX; i++) begin
      host.rd(OFS_DEV_ALIVE, v);
    end
    chk("alive max", ALIVE_MAX, v);
    chk_rd(OFS_DEV_ALIVE, ZERO16);
    chk_rd(OFS_DEV_ALIVE, 16'h0001);
    chk_pins("unarmed", 4'b0000);
    $display("test alive counter done");
    host.beat_zero();
    host.beat();
    repeat (WIN * TICKS - 8) @(posedge sys_clk);
    host.beat();
    chk_pins("beats", 4'b0000);
    host.beat_zero();
    chk_pins("zero ok", 4'b0000);
    host.beat_zero();
    chk_pins("double zero", 4'b1000);
    host.wr(OFS_FAULT_CLEAR, ZERO16);
    chk_pins("clear 0", 4'b1000);
    host.wr(OFS_FAULT_CLEAR, 16'h0002);
    chk_pins("clear 2", 4'b1000);
    host.wr(OFS_FAULT_CLEAR, FAULT_CLR_MAX);
    chk_pins("clear 1", 4'b0000);
    chk_rd(OFS_FAULT_CLEAR, ZERO16);
    chk_cnt("clear pulse", 12'h001);
    chk_rd(OFS_HOST_ALIVE, ZERO16);
    host.wr(OFS_HOST_ALIVE, 16'h0005);
    chk_pins("bad step", 4'b1000);
    host.wr(OFS_FAULT_CLEAR, FAULT_CLR_MAX);
    chk_pins("clear again", 4'b0000);
    repeat (2 * WIN * TICKS + 4) @(posedge sys_clk);
    chk_pins("timeout", 4'b1000);
    $display("test heartbeat done");
    host.wr(OFS_OP_CMD, CMD_STANDBY);
    chk_pins("standby stopped", 4'b1000);
    host.wr(OFS_OP_CMD, CMD_START);
    chk_pins("start", 4'b1110);
    chk_rd(OFS_OP_CMD, ZERO16);
    host.wr(OFS_OP_CMD, CMD_STANDBY);
    chk_pins("standby", 4'b1100);
    host.wr(OFS_OP_CMD, 16'h0005);
    chk_pins("cmd 5", 4'b1100);
    host.wr(OFS_OP_CMD, CMD_RESUME);
    chk_pins("resume", 4'b1110);
    host.wr(OFS_OP_CMD, CMD_STOP);
    chk_pins("stop", 4'b1000);
    chk_cnt("pulses", 12'h112);
    $display("test commands done");
    host.wr(OFS_IRQ_MASK, 16'h0004);
    chk_pins("irq on", 4'b1001);
    host.wr(OFS_IRQ_STATUS, 16'h0004);
    chk_pins("irq off", 4'b1000);
    chk_rd(OFS_IRQ_MASK, 16'h0004);
    chk_rd(OFS_IRQ_STATUS, 16'h0003);
    chk_rd(OFS_DEV_STATUS, 16'h000C);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
